// ### core/pad_pkg.sv
package pad_pkg;
  localparam longint CLK_MHZ = 200;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_SYS_A = 8'h62;
  localparam logic [7:0] IDX_SYS_B = 8'h63;
  localparam logic [7:0] IDX_SYS_C = 8'h64;
  localparam logic [7:0] IDX_HK_A = 8'h65;
  localparam logic [7:0] IDX_HK_B = 8'h66;
  localparam logic [7:0] IDX_IDLE = 8'h67;
  localparam logic [7:0] IDX_TRAP_A = 8'h69;
  localparam logic [7:0] IDX_TRAP_B = 8'h6a;
  localparam logic [7:0] IDX_RANGE_HI = 8'h6b;
  localparam logic [7:0] IDX_RANGE_LO = 8'h6c;
  localparam logic [7:0] IDX_CTRL = 8'h71;
  localparam logic [7:0] IDX_STAT = 8'h73;
  localparam logic [7:0] IDX_DOZE = 8'h8d;
  localparam int CFG_NUM = 11;
  localparam int CFG_SYS_A = int'(IDX_SYS_A - IDX_SYS_A);
  localparam int CFG_SYS_B = int'(IDX_SYS_B - IDX_SYS_A);
  localparam int CFG_SYS_C = int'(IDX_SYS_C - IDX_SYS_A);
  localparam int CFG_HK_A = int'(IDX_HK_A - IDX_SYS_A);
  localparam int CFG_HK_B = int'(IDX_HK_B - IDX_SYS_A);
  localparam int CFG_IDLE = int'(IDX_IDLE - IDX_SYS_A);
  localparam int CFG_TRAP_A = int'(IDX_TRAP_A - IDX_SYS_A);
  localparam int CFG_RANGE_HI = int'(IDX_RANGE_HI - IDX_SYS_A);
  localparam int CFG_RANGE_LO = int'(IDX_RANGE_LO - IDX_SYS_A);
  // Writable bits per config entry, 0x62 to 0x6c
  localparam logic [7:0] CFG_MASK [0:CFG_NUM-1] = '{8'hfe, 8'h20, 8'he0, 8'hfc,
    8'h20, 8'hfc, 8'h00, 8'hfc, 8'h00, 8'hff, 8'hff};
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h84;
  localparam logic [7:0] STAT_MASK = 8'h87;
  localparam logic [7:0] STAT_LOW_SRC = 8'h07;
  localparam int CTRL_DOZE_SMI = 7;
  localparam int CTRL_ACT_SMI = 2;
  localparam int ST_DOZE = 7;
  localparam int ST_SYS = 2;
  localparam int ST_IDLE = 1;
  localparam int ST_TRAP = 0;
  localparam int SYS_A_LSB = 1;
  localparam int SYS_C_LSB = 5;
  localparam int HK_A_LSB = 2;
  localparam int PER_LSB = 2;
  localparam int RANGE_BIT = 5;
  localparam int DOZE_LSB = 5;
  localparam int LO_MEM = 0;
  localparam int LO_WIDE = 1;
  localparam int LO_SZ16 = 2;
  localparam logic [13:0] IO_MASK_4 = 14'h3fff;
  localparam logic [13:0] IO_MASK_8 = 14'h3ffe;
  localparam logic [13:0] IO_MASK_16 = 14'h3ffc;
  localparam logic [2:0] DOZE_OFF = 3'h0;
  localparam logic [2:0] DOZE_50 = 3'h1;
  localparam logic [2:0] DOZE_100 = 3'h2;
  localparam logic [2:0] DOZE_500 = 3'h3;
  localparam logic [2:0] DOZE_RSVD = 3'h4;
  localparam logic [2:0] DOZE_4S = 3'h5;
  localparam logic [2:0] DOZE_8S = 3'h6;
  localparam logic [2:0] DOZE_16S = 3'h7;
  localparam longint DOZE_50_MS = 50;
  localparam longint DOZE_100_MS = 100;
  localparam longint DOZE_500_MS = 500;
  localparam longint DOZE_4_S = 4;
  localparam longint DOZE_8_S = 8;
  localparam longint DOZE_16_S = 16;
  localparam logic [31:0] DOZE_50_CYC = 32'(DOZE_50_MS * CLK_MHZ * 1000);
  localparam logic [31:0] DOZE_100_CYC = 32'(DOZE_100_MS * CLK_MHZ * 1000);
  localparam logic [31:0] DOZE_500_CYC = 32'(DOZE_500_MS * CLK_MHZ * 1000);
  localparam logic [31:0] DOZE_4_CYC = 32'(DOZE_4_S * CLK_MHZ * 1000000);
  localparam logic [31:0] DOZE_8_CYC = 32'(DOZE_8_S * CLK_MHZ * 1000000);
  localparam logic [31:0] DOZE_16_CYC = 32'(DOZE_16_S * CLK_MHZ * 1000000);

  typedef struct packed {
    logic dma_request_activity;
    logic bus_master_activity;
    logic parallel_port_activity;
    logic serial_port_activity;
    logic keyboard_activity;
    logic floppy_activity;
    logic hard_disk_activity;
    logic irq_high_activity;
    logic irq_zero_activity;
    logic nmi_activity;
  } pad_act_t;

  typedef struct packed {
    logic valid;
    logic is_mem;
    logic [31:0] addr;
  } pad_cyc_t;

  typedef enum logic {
    PAD_BUS_IDLE = 1'b0,
    PAD_BUS_ANSWER = 1'b1
  } pad_bus_t;
endpackage

// ### core/pad_range_cmp.sv
`timescale 1ns/100ps
`default_nettype none
module pad_range_cmp
  import pad_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  input wire pad_cyc_t cyc_i,
  output logic hit_o
);
  logic hit_reg, hit_next;
  logic [13:0] io_mask;
  logic mem_eq, io_eq;

  always_comb
  begin
    // Range size trims the low compare bits in IO mode
    if (!lo_i[LO_WIDE])
      io_mask = IO_MASK_4;
    else if (lo_i[LO_SZ16])
      io_mask = IO_MASK_16;
    else
      io_mask = IO_MASK_8;
    mem_eq = cyc_i.addr[31:17] == {hi_i, lo_i[7:1]};
    io_eq = ((cyc_i.addr[15:2] ^ {hi_i, lo_i[7:2]}) & io_mask) == 14'h0000;
    hit_next = cyc_i.valid && (cyc_i.is_mem == lo_i[LO_MEM])
      && (lo_i[LO_MEM] ? mem_eq : io_eq);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hit_reg <= 1'b0;
    else if (ce_i)
      hit_reg <= hit_next;
  end

  assign hit_o = hit_reg;
endmodule
`default_nettype wire

// ### core/pad_detect.sv
`timescale 1ns/100ps
`default_nettype none
module pad_detect
  import pad_pkg::*;
#(
  parameter logic [31:0] DOZE_C50 = DOZE_50_CYC,
  parameter logic [31:0] DOZE_C100 = DOZE_100_CYC,
  parameter logic [31:0] DOZE_C500 = DOZE_500_CYC,
  parameter logic [31:0] DOZE_C4S = DOZE_4_CYC,
  parameter logic [31:0] DOZE_C8S = DOZE_8_CYC,
  parameter logic [31:0] DOZE_C16S = DOZE_16_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire pad_act_t act_i,
  input wire pad_cyc_t cyc_i,
  input wire logic doze_or_standby_i,
  input wire logic periph_timeout_i,
  output logic smi_o,
  output logic timer_reload_o,
  output logic wake_o,
  output logic hk_wake_o,
  output logic doze_timeout_o
);
  logic [7:0] cfg_reg [0:CFG_NUM-1];
  logic [7:0] cfg_next [0:CFG_NUM-1];
  logic [2:0] doze_reg, doze_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] stat_reg, stat_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [5:0] seen_reg, seen_next;
  pad_bus_t bus_reg, bus_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic smi_reg, smi_next;
  logic reload_reg, reload_next;
  logic wake_reg, wake_next;
  logic hk_reg, hk_next;
  logic range_hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_go, doze_wr;
  logic sys_hit, hk_hit, trap_hit, idle_hit, run, expire;
  logic [5:0] periph_act;

  function automatic logic [31:0] doze_load(input logic [2:0] code);
    case (code)
      DOZE_50: doze_load = DOZE_C50;
      DOZE_100: doze_load = DOZE_C100;
      DOZE_500: doze_load = DOZE_C500;
      DOZE_4S: doze_load = DOZE_C4S;
      DOZE_8S: doze_load = DOZE_C8S;
      DOZE_16S: doze_load = DOZE_C16S;
      default: doze_load = 32'h0000_0000;
    endcase
  endfunction

  pad_range_cmp u_range (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .hi_i(cfg_reg[CFG_RANGE_HI]),
    .lo_i(cfg_reg[CFG_RANGE_LO]),
    .cyc_i(cyc_i),
    .hit_o(range_hit)
  );

  // Bus slave: one wait cycle, answer in the next
  always_comb
  begin
    idx = avs_address_i[9:2];
    bus_next = bus_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    case (bus_reg)
      PAD_BUS_IDLE:
      begin
        if (avs_read_i || avs_write_i)
        begin
          bus_next = PAD_BUS_ANSWER;
          wait_next = 1'b0;
          rdata_next = 32'h0000_0000;
          if (avs_read_i)
          begin
            if (idx >= IDX_SYS_A && idx <= IDX_RANGE_LO)
              rdata_next[7:0] = cfg_reg[int'(idx - IDX_SYS_A)];
            else if (idx == IDX_CTRL)
              rdata_next[7:0] = ctrl_reg;
            else if (idx == IDX_STAT)
              rdata_next[7:0] = stat_reg;
            else if (idx == IDX_DOZE)
              rdata_next[7:0] = {doze_reg, 5'h00};
          end
        end
      end
      PAD_BUS_ANSWER:
      begin
        bus_next = PAD_BUS_IDLE;
        wait_next = 1'b1;
      end
      default:
      begin
        bus_next = PAD_BUS_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_reg <= PAD_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      bus_reg <= bus_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Register writes take effect in the answer cycle
  always_comb
  begin
    wbyte = avs_writedata_i[7:0];
    wr_go = avs_write_i && avs_byteenable_i[0] && (bus_reg == PAD_BUS_ANSWER);
    doze_wr = wr_go && (idx == IDX_DOZE);
    for (int i = 0; i < CFG_NUM; i++)
    begin
      cfg_next[i] = cfg_reg[i];
      if (wr_go && idx == 8'(int'(IDX_SYS_A) + i))
        cfg_next[i] = wbyte & CFG_MASK[i];
    end
    ctrl_next = ctrl_reg;
    if (wr_go && idx == IDX_CTRL)
      ctrl_next = wbyte & CTRL_MASK;
    doze_next = doze_reg;
    if (doze_wr)
      doze_next = wbyte[7:DOZE_LSB];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < CFG_NUM; i++)
        cfg_reg[i] <= REG_RST;
      ctrl_reg <= REG_RST;
      doze_reg <= DOZE_OFF;
    end
    else if (ce_i)
    begin
      cfg_reg <= cfg_next;
      ctrl_reg <= ctrl_next;
      doze_reg <= doze_next;
    end
  end

  // Activity detection, doze timer and SMI status
  always_comb
  begin
    periph_act = {act_i.parallel_port_activity, act_i.serial_port_activity,
      act_i.keyboard_activity, act_i.floppy_activity, act_i.hard_disk_activity, range_hit};
    sys_hit = |(cfg_reg[CFG_SYS_A][7:SYS_A_LSB] & {act_i.dma_request_activity,
        act_i.bus_master_activity, act_i.parallel_port_activity,
        act_i.serial_port_activity, act_i.keyboard_activity, act_i.floppy_activity,
        act_i.hard_disk_activity})
      | (cfg_reg[CFG_SYS_B][RANGE_BIT] & range_hit)
      | |(cfg_reg[CFG_SYS_C][7:SYS_C_LSB] & {act_i.irq_high_activity,
        act_i.irq_zero_activity, act_i.nmi_activity});
    hk_hit = doze_or_standby_i &&
      (|(cfg_reg[CFG_HK_A][7:HK_A_LSB] & {act_i.dma_request_activity,
        act_i.bus_master_activity, act_i.keyboard_activity, act_i.irq_high_activity,
        act_i.irq_zero_activity, act_i.nmi_activity})
      | (cfg_reg[CFG_HK_B][RANGE_BIT] & range_hit));
    trap_hit = |(cfg_reg[CFG_TRAP_A][7:PER_LSB] & periph_act);
    idle_hit = periph_timeout_i
      && |(cfg_reg[CFG_IDLE][7:PER_LSB] & ~(seen_reg | periph_act));
    seen_next = periph_timeout_i ? periph_act : (seen_reg | periph_act);

    run = (doze_reg != DOZE_OFF) && (doze_reg != DOZE_RSVD) && !stat_reg[ST_DOZE];
    expire = run && !sys_hit && !doze_wr && (cnt_reg == 32'h0000_0001);
    cnt_next = cnt_reg;
    if (sys_hit || doze_wr)
      cnt_next = doze_load(doze_next);
    else if (expire)
      cnt_next = doze_load(doze_reg);
    else if (run)
      cnt_next = cnt_reg - 32'h0000_0001;

    reload_next = sys_hit;
    wake_next = sys_hit && !ctrl_reg[CTRL_ACT_SMI] && doze_or_standby_i;
    hk_next = hk_hit;

    // Software clears by writing ones; hardware sets win
    stat_next = stat_reg;
    if (wr_go && idx == IDX_STAT)
      stat_next = stat_reg & ~(wbyte & STAT_MASK);
    if (wake_next)
      stat_next[ST_DOZE] = 1'b0;
    if (expire)
      stat_next[ST_DOZE] = 1'b1;
    if (sys_hit && ctrl_reg[CTRL_ACT_SMI])
      stat_next[ST_SYS] = 1'b1;
    if (idle_hit)
      stat_next[ST_IDLE] = 1'b1;
    if (trap_hit)
      stat_next[ST_TRAP] = 1'b1;
    smi_next = |(stat_next & STAT_LOW_SRC)
      || (stat_next[ST_DOZE] && ctrl_next[CTRL_DOZE_SMI]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_reg <= REG_RST;
      cnt_reg <= 32'h0000_0000;
      seen_reg <= 6'h00;
      smi_reg <= 1'b0;
      reload_reg <= 1'b0;
      wake_reg <= 1'b0;
      hk_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      stat_reg <= stat_next;
      cnt_reg <= cnt_next;
      seen_reg <= seen_next;
      smi_reg <= smi_next;
      reload_reg <= reload_next;
      wake_reg <= wake_next;
      hk_reg <= hk_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign smi_o = smi_reg;
  assign timer_reload_o = reload_reg;
  assign wake_o = wake_reg;
  assign hk_wake_o = hk_reg;
  assign doze_timeout_o = stat_reg[ST_DOZE];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  smi_clear_a: assert property ((stat_reg == 8'h00) |-> !smi_o)
    else $error("SMI stays high with no cause");
  reset_zero_a: assert property ($past(rst_i) |-> (cfg_reg[CFG_SYS_A] == 8'h00)
      && (cfg_reg[CFG_TRAP_A] == 8'h00) && (cfg_reg[CFG_RANGE_LO] == 8'h00) && !smi_o)
    else $error("Registers not zero after reset");
  act_reload_a: assert property (ce_i && sys_hit |=> timer_reload_o)
    else $error("System activity did not reload timers");
  act_smi_a: assert property (ce_i && sys_hit && ctrl_reg[CTRL_ACT_SMI]
      |=> stat_reg[ST_SYS] && smi_o)
    else $error("System activity did not raise SMI");
  act_wake_a: assert property (ce_i && sys_hit && !ctrl_reg[CTRL_ACT_SMI]
      && doze_or_standby_i |=> wake_o && timer_reload_o)
    else $error("System activity did not wake");
  hk_state_a: assert property (ce_i && !doze_or_standby_i |=> !hk_wake_o)
    else $error("Housekeeping event outside doze or standby");
  trap_smi_a: assert property (ce_i && trap_hit |=> stat_reg[ST_TRAP] && smi_o)
    else $error("Trapped access did not raise SMI");
  doze_hold_a: assert property (ce_i && stat_reg[ST_DOZE] && !sys_hit && !doze_wr
      |=> $stable(cnt_reg))
    else $error("Doze timer counted with flag set");
  idle_smi_a: assert property (ce_i && idle_hit |=> stat_reg[ST_IDLE] && smi_o)
    else $error("Idle peripheral did not raise SMI");

  // Enable bits reach the reload and wake pulses
  hdc_sys_a: assert property (ce_i && cfg_reg[CFG_SYS_A][SYS_A_LSB]
      && act_i.hard_disk_activity |=> timer_reload_o)
    else $error("Enabled disk activity did not reload timers");
  nmi_sys_a: assert property (ce_i && cfg_reg[CFG_SYS_C][SYS_C_LSB]
      && act_i.nmi_activity |=> timer_reload_o)
    else $error("Enabled NMI activity did not reload timers");
  range_sys_a: assert property (ce_i && range_hit && cfg_reg[CFG_SYS_B][RANGE_BIT]
      |=> timer_reload_o)
    else $error("Range activity did not reload timers");
  hk_nmi_a: assert property (ce_i && doze_or_standby_i && cfg_reg[CFG_HK_A][HK_A_LSB]
      && act_i.nmi_activity |=> hk_wake_o)
    else $error("Housekeeping NMI activity did not wake");
  hk_range_a: assert property (ce_i && doze_or_standby_i && range_hit
      && cfg_reg[CFG_HK_B][RANGE_BIT] |=> hk_wake_o)
    else $error("Housekeeping range activity did not wake");

  // Doze timer steps
  doze_count_a: assert property (ce_i && run && !sys_hit && !doze_wr
      && (cnt_reg > 32'h0000_0001) |=> cnt_reg == $past(cnt_reg) - 32'h0000_0001)
    else $error("Doze timer did not count down");
  doze_expire_a: assert property (ce_i && expire |=> doze_timeout_o)
    else $error("Doze timer expired without status");
  doze_rsvd_a: assert property (ce_i && (doze_reg == DOZE_RSVD)
      && !sys_hit && !doze_wr |=> $stable(cnt_reg))
    else $error("Doze timer ran on reserved code");

  // SMI release once every cause is cleared
  smi_fall_a: assert property (ce_i && wr_go && (idx == IDX_STAT)
      && (wbyte == STAT_MASK) && !sys_hit && !trap_hit && !idle_hit && !expire
      |=> !smi_o)
    else $error("SMI still high after all causes cleared");
endmodule
`default_nettype wire

// ### tb/pad_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pad_host_model
  import pad_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic smi_i,
  output var pad_cyc_t cyc_o
);
  int smi_count;
  logic smi_q;

  initial cyc_o = '0;

  // Counts SMI requests as the processor sees them
  always @(posedge clk_i)
  begin
    smi_q <= smi_i;
    if (rst_i)
      smi_count <= 0;
    else if (smi_i && !smi_q)
      smi_count <= smi_count + 1;
  end

  // One bus cycle for one clock; idle lines show a scrambled address
  task automatic issue(input logic mem, input logic [31:0] a);
    cyc_o <= '{valid: 1'b1, is_mem: mem, addr: a};
    @(posedge clk_i);
    cyc_o <= '{valid: 1'b0, is_mem: !mem, addr: ~a};
  endtask
endmodule
`default_nettype wire

// ### tb/tb_pad_detect.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pad_detect
  import pad_pkg::*;
;
  logic clk_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i;
  pad_act_t act_i;
  pad_cyc_t cyc_i;
  logic doze_or_standby_i, periph_timeout_i;
  logic smi_o, timer_reload_o, wake_o, hk_wake_o, doze_timeout_o;
  logic [4:0] o;
  int mismatches, compares, cycles;
  localparam logic [7:0] MASK [0:10] = '{8'hfe, 8'h20, 8'he0, 8'hfc, 8'h20, 8'hfc, 8'h00,
    8'hfc, 8'h00, 8'hff, 8'hff};
  localparam int HK_ACT [2:7] = '{0, 1, 2, 5, 8, 9};
  // Code 1 keeps its full count, so it must not expire in the window
  localparam int DZ [0:7] = '{0, 0, 20, 30, 0, 40, 50, 60};

  assign o = {doze_timeout_o, hk_wake_o, wake_o, timer_reload_o, smi_o};

  pad_detect #(.DOZE_C100(20), .DOZE_C500(30), .DOZE_C4S(40),
    .DOZE_C8S(50), .DOZE_C16S(60)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .act_i(act_i), .cyc_i(cyc_i), .doze_or_standby_i(doze_or_standby_i),
    .periph_timeout_i(periph_timeout_i), .smi_o(smi_o), .timer_reload_o(timer_reload_o),
    .wake_o(wake_o), .hk_wake_o(hk_wake_o), .doze_timeout_o(doze_timeout_o));

  pad_host_model HOST (.clk_i(clk_i), .rst_i(rst_i), .smi_i(smi_o), .cyc_o(cyc_i));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    input logic [3:0] be);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= 32'(d);
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    check(rd, 32'(exp));
  endtask

  // Samples one output over four edges, true if it was ever high
  task automatic seen(input int sel, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (4)
    begin
      @(posedge clk_i);
      hit |= (o[sel] === 1'b1);
    end
    check(32'(hit), 32'(exp));
  endtask

  task automatic strobe(input int ab);
    act_i <= pad_act_t'(10'(1) << ab);
    @(posedge clk_i);
    act_i <= '0;
  endtask

  task automatic tmo();
    periph_timeout_i <= 1'b1;
    @(posedge clk_i);
    periph_timeout_i <= 1'b0;
  endtask

  task automatic try(input logic [7:0] idx, input int k, input int ab, input int sel,
    input logic exp);
    wr(idx, 8'(1 << k));
    strobe(ab);
    seen(sel, exp);
    wr(idx, 8'h00);
    wr(IDX_STAT, 8'h87);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 11; i++)
      rdchk(IDX_SYS_A + 8'(i), 8'h00);
    for (int i = 0; i < 11; i++)
    begin
      wr(IDX_SYS_A + 8'(i), 8'hff);
      rdchk(IDX_SYS_A + 8'(i), MASK[i]);
      wr(IDX_SYS_A + 8'(i), 8'h00);
    end
    bus(1'b1, IDX_RANGE_HI, 8'h5a, 4'h0);
    rdchk(IDX_RANGE_HI, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_act();
    for (int k = 1; k < 8; k++)
      try(IDX_SYS_A, k, k + 2, 1, 1'b1);
    try(IDX_SYS_A, 7, 8, 1, 1'b0);
    for (int k = 5; k < 8; k++)
      try(IDX_SYS_C, k, k - 5, 1, 1'b1);
    doze_or_standby_i <= 1'b1;
    for (int k = 2; k < 8; k++)
      try(IDX_HK_A, k, HK_ACT[k], 3, 1'b1);
    try(IDX_SYS_A, 7, 9, 2, 1'b1);
    doze_or_standby_i <= 1'b0;
    try(IDX_HK_A, 7, 9, 3, 1'b0);
    try(IDX_SYS_A, 7, 9, 2, 1'b0);
    wr(IDX_SYS_A, 8'h80);
    ce_i <= 1'b0;
    strobe(9);
    seen(1, 1'b0);
    ce_i <= 1'b1;
    strobe(9);
    seen(1, 1'b1);
    wr(IDX_CTRL, 8'h04);
    wr(IDX_SYS_A, 8'h80);
    strobe(9);
    seen(0, 1'b1);
    check(32'(HOST.smi_count), 32'h0000_0001);
    rdchk(IDX_STAT, 8'h04);
    wr(IDX_STAT, 8'h04);
    repeat (3) @(posedge clk_i);
    check(32'(smi_o), 32'h0000_0000);
    wr(IDX_SYS_A, 8'h00);
    wr(IDX_CTRL, 8'h00);
    $display("test activity done");
  endtask

  task automatic rng(input logic [7:0] lo, input logic mem, input logic [31:0] a,
    input logic exp);
    wr(IDX_RANGE_LO, lo);
    HOST.issue(mem, a);
    seen(1, exp);
  endtask

  task automatic t_range();
    wr(IDX_SYS_B, 8'h20);
    wr(IDX_RANGE_HI, 8'ha5);
    rng(8'h37, 1'b1, 32'ha536_0000, 1'b1);
    rng(8'h37, 1'b1, 32'ha534_0000, 1'b0);
    rng(8'h37, 1'b1, 32'ha532_0000, 1'b0);
    rng(8'h37, 1'b0, 32'ha536_0000, 1'b0);
    wr(IDX_RANGE_HI, 8'h12);
    rng(8'h34, 1'b0, 32'h0000_1234, 1'b1);
    rng(8'h34, 1'b0, 32'h0000_1230, 1'b0);
    rng(8'h32, 1'b0, 32'h0000_1234, 1'b1);
    rng(8'h32, 1'b0, 32'h0000_1238, 1'b0);
    rng(8'h36, 1'b0, 32'h0000_123c, 1'b1);
    rng(8'h36, 1'b0, 32'h0000_1334, 1'b0);
    rng(8'h36, 1'b1, 32'h0000_1234, 1'b0);
    wr(IDX_SYS_B, 8'h00);
    wr(IDX_HK_B, 8'h20);
    doze_or_standby_i <= 1'b1;
    HOST.issue(1'b0, 32'h0000_1234);
    seen(3, 1'b1);
    doze_or_standby_i <= 1'b0;
    wr(IDX_HK_B, 8'h00);
    $display("test range done");
  endtask

  // Unused peripheral found idle first, then trapped
  task automatic t_idle();
    wr(IDX_IDLE, 8'h80);
    tmo();
    wr(IDX_STAT, 8'h87);
    tmo();
    seen(0, 1'b1);
    rdchk(IDX_STAT, 8'h02);
    wr(IDX_STAT, 8'h87);
    strobe(7);
    tmo();
    seen(0, 1'b0);
    wr(IDX_IDLE, 8'h00);
    for (int k = 3; k < 8; k++)
      try(IDX_TRAP_A, k, k, 0, 1'b1);
    wr(IDX_TRAP_A, 8'h04);
    HOST.issue(1'b0, 32'h0000_123c);
    seen(0, 1'b1);
    rdchk(IDX_STAT, 8'h01);
    wr(IDX_TRAP_A, 8'h00);
    wr(IDX_STAT, 8'h87);
    $display("test idle and trap done");
  endtask

  task automatic t_doze();
    int n;
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_DOZE, 8'h00);
      wr(IDX_STAT, 8'h80);
      wr(IDX_DOZE, 8'(c << 5));
      n = 0;
      while (doze_timeout_o !== 1'b1 && n < 100)
      begin
        @(posedge clk_i);
        n++;
      end
      if (DZ[c] == 0)
        check(32'(n), 32'd100);
      else
        check(32'(n >= DZ[c] - 2 && n <= DZ[c] + 2), 32'h0000_0001);
    end
    $display("test doze done");
  endtask

  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'h0;
    act_i = '0;
    doze_or_standby_i = 1'b0;
    periph_timeout_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_act();
    t_range();
    t_idle();
    t_doze();
    end_of_test();
  end
endmodule
`default_nettype wire
